// file: design/iomux_top.sv
// Purpose: apb controlled 32-line parallel io port with peripheral mux
// Assumes: zero wait state apb, pins synchronous to pclk
// Notes: pad output enable is active low; peripheral inputs see raw pins
// Contract
// R1 - each line uses the same bit index in every 32-bit register
// R2 - pull-up enable write clears off-status, disable write sets it
// R3 - pull-up writes act regardless of ownership or direction
// R4 - pull-up off-status resets to zero, all pull-ups on
// R5 - port enable/disable writes set/clear ownership; one means port owns
// R6 - lines without peripheral ignore ownership writes and read one
// R7 - ownership reset value comes from a product parameter
// R8 - select bit zero picks peripheral a, one picks peripheral b
// R9 - select affects outputs only; pins feed both peripheral inputs
// R10 - peripheral select resets to zero
// R11 - select writes accepted always; software also disables port ownership
// R12 - peripheral-owned line takes drive enable and value from selected peripheral
// R13 - drive enable/disable writes set/clear drive status; port drives when one
// R14 - level set/clear writes set/clear output level data
// R15 - drive and level writes update even while peripheral owns line
// R16 - direct level write changes only bits whose mask status is one
// R17 - direct write mask resets to zero
// R18 - open drain writes set/clear status; set lines never drive high
// R19 - open drain accepted regardless of owner; resets to zero
// R20 - pin readback shows actual pad level in every configuration
// R21 - with port clock stopped, readback holds last captured levels
// R22 - zero bits leave status unchanged; set/clear registers read zero
// R23 - pad outputs registered; pin inputs pass two-stage synchroniser
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module iomux_top #(
  parameter logic [31:0] PERIPH_LINES = iomux_pkg::PERIPH_LINES_DEF,
  parameter logic [31:0] OWN_RST = iomux_pkg::OWN_RST_DEF
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iomux_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port clock state from power control
  input wire logic clk_on,
  // pads
  input wire logic [iomux_pkg::NLINES-1:0] pad_in,
  output logic [iomux_pkg::NLINES-1:0] pad_out,
  output logic [iomux_pkg::NLINES-1:0] pad_oe_n,
  output logic [iomux_pkg::NLINES-1:0] pullup_on,
  // peripheral a
  input wire logic [iomux_pkg::NLINES-1:0] pa_out,
  input wire logic [iomux_pkg::NLINES-1:0] pa_oe,
  output logic [iomux_pkg::NLINES-1:0] pa_in,
  // peripheral b
  input wire logic [iomux_pkg::NLINES-1:0] pb_out,
  input wire logic [iomux_pkg::NLINES-1:0] pb_oe,
  output logic [iomux_pkg::NLINES-1:0] pb_in
);
  import iomux_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] pullup_off_status;
  logic [31:0] line_owner_status;
  logic [31:0] periph_select;
  logic [31:0] drive_status;
  logic [31:0] out_level_data;
  logic [31:0] direct_write_mask_status;
  logic [31:0] open_drain_status;
  logic [31:0] pin_level_readback;
  logic [31:0] next_out;
  logic [31:0] next_drive;
  logic wr;
  logic rd_setup;

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // true for every mapped offset
  function automatic logic addr_hit(input logic [AW-1:0] a);
    unique case (a)
      OWN_EN, OWN_DIS, OWN_STAT, DRV_EN, DRV_DIS, DRV_STAT,
      LVL_SET, LVL_CLR, LVL_DATA, PIN_READ, OD_EN, OD_DIS, OD_STAT,
      PU_DIS, PU_EN, PU_STAT, PSEL_REG, MASK_SET, MASK_CLR,
      MASK_STAT: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // mask of bits a write at this offset touches
  function automatic logic [31:0] wsel(input logic [AW-1:0] a,
                                        input logic [AW-1:0] r);
    wsel = (wr && a == r) ? pwdata : ZERO;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // apb handshake: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign wr = psel & penable & pwrite & addr_hit(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  // read data is captured in setup so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO;
    end else if (rd_setup) begin
      unique case (paddr)
        OWN_STAT: prdata <= line_owner_status;
        DRV_STAT: prdata <= drive_status;
        LVL_DATA: prdata <= out_level_data;
        PIN_READ: prdata <= pin_level_readback; // R20
        OD_STAT: prdata <= open_drain_status;
        PU_STAT: prdata <= pullup_off_status;
        PSEL_REG: prdata <= periph_select;
        MASK_STAT: prdata <= direct_write_mask_status;
        default: prdata <= ZERO; // R22
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers; a zero bit in a set/clear write keeps state

  // pull-ups ignore ownership and direction entirely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_off_status <= PU_RST; // R4
    end else begin
      pullup_off_status <= (pullup_off_status | wsel(paddr, PU_DIS))
                           & ~wsel(paddr, PU_EN); // R2 R3 R22
    end
  end

  // lines with no peripheral are pinned to port ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_owner_status <= OWN_RST | ~PERIPH_LINES; // R7 R6
    end else begin
      line_owner_status <= ((line_owner_status | wsel(paddr, OWN_EN))
                            & ~wsel(paddr, OWN_DIS))
                           | ~PERIPH_LINES; // R5 R6 R22
    end
  end

  // peripheral select is plain read/write and ignores ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_select <= PSEL_RST; // R10
    end else if (wr && paddr == PSEL_REG) begin
      periph_select <= pwdata; // R11
    end
  end

  // drive status updates even on peripheral-owned lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_status <= DRV_RST;
    end else begin
      drive_status <= (drive_status | wsel(paddr, DRV_EN))
                      & ~wsel(paddr, DRV_DIS); // R13 R15 R22
    end
  end

  // level data: set, clear or masked direct write, never two at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level_data <= LVL_RST;
    end else if (wr && paddr == LVL_DATA) begin
      out_level_data <= (out_level_data & ~direct_write_mask_status)
                        | (pwdata & direct_write_mask_status); // R16
    end else begin
      out_level_data <= (out_level_data | wsel(paddr, LVL_SET))
                        & ~wsel(paddr, LVL_CLR); // R14 R15 R22
    end
  end

  // mask for direct level writes, closed after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_write_mask_status <= MASK_RST; // R17
    end else begin
      direct_write_mask_status <= (direct_write_mask_status
                                   | wsel(paddr, MASK_SET))
                                  & ~wsel(paddr, MASK_CLR); // R16 R22
    end
  end

  // open drain selection is independent of ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_drain_status <= OD_RST; // R19
    end else begin
      open_drain_status <= (open_drain_status | wsel(paddr, OD_EN))
                           & ~wsel(paddr, OD_DIS); // R18 R19 R22
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pad side

  // output selection per line
  iomux_line_drive u_drive (
    .own(line_owner_status),
    .sel_b(periph_select),
    .drv(drive_status),
    .lvl(out_level_data),
    .od(open_drain_status),
    .pa_out(pa_out),
    .pa_oe(pa_oe),
    .pb_out(pb_out),
    .pb_oe(pb_oe),
    .next_out(next_out),
    .next_drive(next_drive)
  );

  // registered pad drive costs one cycle but keeps pads glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= ZERO;
      pad_oe_n <= ONES;
    end else begin
      pad_out <= next_out; // R23
      pad_oe_n <= ~next_drive; // R23
    end
  end

  // pull-up is on while its off-status bit is clear
  assign pullup_on = ~pullup_off_status; // R2

  // peripheral inputs see the pin whatever the a/b choice
  assign pa_in = pad_in; // R9
  assign pb_in = pad_in; // R9

  // readback path, frozen while the port clock is off
  iomux_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pad_in),
    .clk_on(clk_on),
    .level(pin_level_readback)
  );

  ////////////////////////////////////////////////////////////////////
  // checks

  pullup_reset_a: assert property (@(posedge pclk) $rose(presetn)
    |-> pullup_off_status == ZERO && direct_write_mask_status == ZERO) // R4
    else $error("pull-up or mask status not zero after reset");

  pullup_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == PU_EN |=> (pullup_off_status & $past(pwdata)) == ZERO) // R2
    else $error("pull-up enable write did not clear status");

  owner_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_owner_status & ~PERIPH_LINES) == ~PERIPH_LINES) // R6
    else $error("line without peripheral lost port ownership");

  owner_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OWN_DIS |=>
    (line_owner_status & $past(pwdata) & PERIPH_LINES) == ZERO) // R5
    else $error("port disable write did not release line");

  direct_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == LVL_DATA |=> ((out_level_data ^ $past(out_level_data))
    & ~$past(direct_write_mask_status)) == ZERO) // R16
    else $error("direct write changed a masked line");

  open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pad_out & ~pad_oe_n & $past(open_drain_status)) == ZERO)) // R18
    else $error("open drain line driven high");

  port_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((~pad_oe_n ^ $past(drive_status)) & $past(line_owner_status)
    & ~$past(open_drain_status)) == ZERO) // R13
    else $error("port-owned drive does not follow drive status");

  periph_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pad_out ^ ($past(periph_select) & $past(pb_out) | ~$past(periph_select) & $past(pa_out)))
    & ~$past(line_owner_status) & ~$past(open_drain_status)) == ZERO) // R8
    else $error("peripheral output not taken from selected side");

  level_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == LVL_SET |=> (~out_level_data & $past(pwdata)) == ZERO) // R14
    else $error("level set write did not set data");

  readback_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_on && $past(presetn, 2) |-> ##1 pin_level_readback == $past(pad_in, 3)) // R23
    else $error("readback is not the pin delayed through sync");

  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_on |=> $stable(pin_level_readback)) // R21
    else $error("readback moved while port clock off");

  setonly_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && paddr == PU_EN |=> prdata == ZERO) // R22
    else $error("write-only register read non-zero");

  periph_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    ##1 ((~pad_oe_n ^ ($past(periph_select) & $past(pb_oe) | ~$past(periph_select) & $past(pa_oe)))
    & ~$past(line_owner_status) & ~$past(open_drain_status)) == ZERO)
    else $error("peripheral drive enable not taken from selected side");

  pullup_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    wr && paddr == PU_DIS |=> (~pullup_off_status & $past(pwdata)) == ZERO)
    else $error("pull-up disable write did not set status");

  owner_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    wr && paddr == OWN_EN |=> (~line_owner_status & $past(pwdata)) == ZERO)
    else $error("port enable write did not take the line");

  drive_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    wr && paddr == DRV_EN |=> (~drive_status & $past(pwdata)) == ZERO)
    else $error("drive enable write did not set status");

  drive_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    wr && paddr == DRV_DIS |=> (drive_status & $past(pwdata)) == ZERO)
    else $error("drive disable write did not clear status");

  level_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wr && paddr == LVL_CLR |=> (out_level_data & $past(pwdata)) == ZERO)
    else $error("level clear write did not clear data");

  mask_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    wr && paddr == MASK_SET |=> (~direct_write_mask_status & $past(pwdata)) == ZERO)
    else $error("mask set write did not open the mask");

  od_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
    wr && paddr == OD_EN |=> (~open_drain_status & $past(pwdata)) == ZERO)
    else $error("open drain enable write did not set status");

  select_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    wr && paddr == PSEL_REG |=> periph_select == $past(pwdata))
    else $error("peripheral select write not taken");

  zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    wr && paddr == DRV_EN |=> (drive_status & ~$past(pwdata))
    == ($past(drive_status) & ~$past(pwdata)))
    else $error("zero bit of a set write changed drive status");

  status_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    wr && paddr == DRV_STAT |=> $stable(drive_status))
    else $error("write to a status register changed it");
endmodule
`default_nettype wire

// file: design/iomux_pkg.sv
// Purpose: shared constants for the io line output mux control block
// Assumes: apb slave, 32-bit data, word aligned offsets
// Notes: offsets are byte addresses
package iomux_pkg;
  localparam int NLINES = 32;
  localparam int AW = 8;
  // write-only set/clear registers read back as zero
  localparam logic [7:0] OWN_EN = 8'h00;
  localparam logic [7:0] OWN_DIS = 8'h04;
  localparam logic [7:0] OWN_STAT = 8'h08;
  localparam logic [7:0] DRV_EN = 8'h10;
  localparam logic [7:0] DRV_DIS = 8'h14;
  localparam logic [7:0] DRV_STAT = 8'h18;
  localparam logic [7:0] LVL_SET = 8'h30;
  localparam logic [7:0] LVL_CLR = 8'h34;
  localparam logic [7:0] LVL_DATA = 8'h38;
  localparam logic [7:0] PIN_READ = 8'h3C;
  localparam logic [7:0] OD_EN = 8'h50;
  localparam logic [7:0] OD_DIS = 8'h54;
  localparam logic [7:0] OD_STAT = 8'h58;
  localparam logic [7:0] PU_DIS = 8'h60;
  localparam logic [7:0] PU_EN = 8'h64;
  localparam logic [7:0] PU_STAT = 8'h68;
  localparam logic [7:0] PSEL_REG = 8'h70;
  localparam logic [7:0] MASK_SET = 8'hA0;
  localparam logic [7:0] MASK_CLR = 8'hA4;
  localparam logic [7:0] MASK_STAT = 8'hA8;
  // reset values
  localparam logic [31:0] PU_RST = 32'h00000000;
  localparam logic [31:0] PSEL_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam logic [31:0] OD_RST = 32'h00000000;
  localparam logic [31:0] DRV_RST = 32'h00000000;
  localparam logic [31:0] LVL_RST = 32'h00000000;
  localparam logic [31:0] ZERO = 32'h00000000;
  localparam logic [31:0] ONES = 32'hFFFFFFFF;
  // product defaults: which lines carry a peripheral, owner at reset
  localparam logic [31:0] PERIPH_LINES_DEF = 32'hFFFFFFFF;
  localparam logic [31:0] OWN_RST_DEF = 32'hFFFFFFFF;
endpackage

// file: design/iomux_pin_sync.sv
// Purpose: two-stage pin synchroniser with freeze while port clock off
// Assumes: clk_on is synchronous to pclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module iomux_pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and gating
  input wire logic [iomux_pkg::NLINES-1:0] pin_in,
  input wire logic clk_on,
  // frozen level
  output logic [iomux_pkg::NLINES-1:0] level
);
  import iomux_pkg::*;
  logic [NLINES-1:0] stage1;
  logic [NLINES-1:0] stage2;

  // sampling chain; hold the last capture when the port clock stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= ZERO;
      stage2 <= ZERO;
      level <= ZERO;
    end else begin
      stage1 <= pin_in; // R23
      stage2 <= stage1;
      if (clk_on) begin // R21
        level <= stage2;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/iomux_line_drive.sv
// Purpose: per-line output selection between port and peripherals
// Assumes: all inputs registered upstream or from peripherals
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ns
`default_nettype none
module iomux_line_drive (
  // configuration
  input wire logic [iomux_pkg::NLINES-1:0] own,
  input wire logic [iomux_pkg::NLINES-1:0] sel_b,
  input wire logic [iomux_pkg::NLINES-1:0] drv,
  input wire logic [iomux_pkg::NLINES-1:0] lvl,
  input wire logic [iomux_pkg::NLINES-1:0] od,
  // peripheral side
  input wire logic [iomux_pkg::NLINES-1:0] pa_out,
  input wire logic [iomux_pkg::NLINES-1:0] pa_oe,
  input wire logic [iomux_pkg::NLINES-1:0] pb_out,
  input wire logic [iomux_pkg::NLINES-1:0] pb_oe,
  // next pad values
  output logic [iomux_pkg::NLINES-1:0] next_out,
  output logic [iomux_pkg::NLINES-1:0] next_drive
);
  import iomux_pkg::*;
  genvar i;
  // one mux per line; open drain only ever drives low
  for (i = 0; i < NLINES; i++) begin : g_line // R1
    logic v;
    logic e;
    assign v = own[i] ? lvl[i] : (sel_b[i] ? pb_out[i] : pa_out[i]); // R8 R12
    assign e = own[i] ? drv[i] : (sel_b[i] ? pb_oe[i] : pa_oe[i]); // R12 R13
    assign next_out[i] = od[i] ? 1'b0 : v; // R18
    assign next_drive[i] = od[i] ? (e & ~v) : e; // R18
  end
endmodule
`default_nettype wire

// file: test/iomux_pads.sv
// Purpose: pad model that resolves each line from the port drive and the pull-up
// Assumes: no external driver on the board, only the internal pull-up
// Notes: a floating line without a pull-up shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module iomux_pads
  import iomux_pkg::*;
(
  // clock for the last-level register of the drift model
  input wire logic pclk,
  // port side of the pads
  input wire logic [iomux_pkg::NLINES-1:0] pad_out,
  input wire logic [iomux_pkg::NLINES-1:0] pad_oe_n,
  input wire logic [iomux_pkg::NLINES-1:0] pullup_on,
  // level seen on the wire
  output logic [iomux_pkg::NLINES-1:0] pad_in
);
  logic [NLINES-1:0] last = '0;

  ////////////////////////////////////////////////////////////////
  // last level, so that a floating line never settles to a stale value
  always_ff @(posedge pclk) begin
    last <= pad_in;
  end

  // the wire follows the driver, else the pull-up, else drifts
  always_comb begin
    for (int i = 0; i < NLINES; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (pullup_on[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: test/iomux_top_tb.sv
// Purpose: self-checking bench for the io line mux control block
// Assumes: lines 16 to 31 carry no peripheral; lines 4 to 7 reset to peripheral
// Notes: apb master holds every request until pready is sampled high or 20 cycles pass
`timescale 1ns/1ns
`default_nettype none
module iomux_top_tb;
  import iomux_pkg::*;
  localparam logic [31:0] PL = 32'h0000FFFF;
  localparam logic [31:0] ORST = 32'hFFFFFF0F;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clk_on = 1'b1;
  logic [31:0] pad_in, pad_out, pad_oe_n, pullup_on, pa_in, pb_in;
  logic [31:0] pa_out = '0;
  logic [31:0] pa_oe = '0;
  logic [31:0] pb_out = '0;
  logic [31:0] pb_oe = '0;
  int num_errors = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////
  // clock and the two instances
  always #5 pclk = ~pclk;

  iomux_top #(.PERIPH_LINES(PL), .OWN_RST(ORST)) iomux_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_on(clk_on), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pullup_on(pullup_on), .pa_out(pa_out), .pa_oe(pa_oe), .pa_in(pa_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_in(pb_in));

  iomux_pads iomux_pads_inst (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pullup_on(pullup_on), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////////
  // comparison, verdict and the apb master
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bounded wait on pready; a stuck slave ends the run
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    bit done;
    done = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        done = 1;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    check(q, exp);
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  // reset value, then set and clear with zero bits that must not disturb
  task automatic triplet(input logic [AW-1:0] s, input logic [AW-1:0] c, input logic [AW-1:0] st,
                         input logic [31:0] init, input logic [31:0] f);
    rd(st, init | f);
    rd(s, 32'h00000000);
    wr(s, 32'h0F0F00F0);
    rd(st, init | 32'h0F0F00F0 | f);
    wr(c, 32'h000F0030);
    rd(st, ((init | 32'h0F0F00F0) & ~32'h000F0030) | f);
    rd(c, 32'h00000000);
  endtask

  task automatic mask_test();
    wr(MASK_CLR, ONES);
    wr(MASK_SET, 32'h0000FFFF);
    wr(LVL_CLR, ONES);
    wr(LVL_SET, 32'hFF00FF00);
    wr(LVL_DATA, 32'h12345678);
    rd(LVL_DATA, 32'hFF005678);
  endtask

  // port drives every line, then one byte lane goes open drain
  task automatic drive_test();
    wr(OWN_EN, ONES);
    wr(DRV_EN, ONES);
    wr(OD_DIS, ONES);
    wr(PU_EN, ONES);
    @(negedge pclk);
    check(pullup_on, ONES);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(pad_oe_n, 32'h00000000);
    check(pad_out, 32'hFF005678);
    wr(OD_EN, 32'h0000FF00);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(pad_oe_n, 32'h00005600);
    check(pad_out & 32'h0000FF00, 32'h00000000);
    repeat (5) @(posedge pclk);
    rd(PIN_READ, 32'hFF005678);
  endtask

  // readback must hold while the port clock is off
  task automatic freeze_test();
    @(posedge pclk);
    clk_on <= 1'b0;
    wr(LVL_SET, ONES);
    repeat (6) @(posedge pclk);
    rd(PIN_READ, 32'hFF005678);
    clk_on <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(PIN_READ, ONES);
  endtask

  // low half to peripherals: bytes 0 from a, byte 1 from b
  task automatic periph_test();
    @(posedge pclk);
    pa_out <= 32'h000000F0;
    pa_oe <= 32'h000000FF;
    pb_out <= 32'h00003C00;
    pb_oe <= 32'h0000F000;
    wr(OD_DIS, ONES);
    wr(PSEL_REG, 32'h0000FF00);
    rd(PSEL_REG, 32'h0000FF00);
    wr(OWN_DIS, ONES);
    rd(OWN_STAT, 32'hFFFF0000);
    wr(DRV_DIS, 32'h0000FFFF);
    rd(DRV_STAT, 32'hFFFF0000);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(pad_oe_n, 32'h00000F00);
    check(pad_out, 32'hFFFF3CF0);
    check(pa_in, 32'hFFFF3FF0);
    check(pb_in, 32'hFFFF3FF0);
    repeat (5) @(posedge pclk);
    rd(PIN_READ, 32'hFFFF3FF0);
  endtask

  task automatic refuse_test();
    logic [31:0] q;
    logic e;
    apb(1'b1, 8'hFC, ONES, q, e);
    check(e, 32'h00000001);
    apb(1'b0, 8'hFC, 32'h00000000, q, e);
    check(q, 32'h00000000);
    wr(DRV_STAT, 32'h00000000);
    rd(DRV_STAT, 32'hFFFF0000);
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    check(pad_oe_n, ONES);
    presetn <= 1'b1;
    rd(PSEL_REG, 32'h00000000);
    triplet(OWN_EN, OWN_DIS, OWN_STAT, ORST, ~PL);
    triplet(DRV_EN, DRV_DIS, DRV_STAT, ZERO, ZERO);
    triplet(LVL_SET, LVL_CLR, LVL_DATA, ZERO, ZERO);
    triplet(OD_EN, OD_DIS, OD_STAT, ZERO, ZERO);
    triplet(MASK_SET, MASK_CLR, MASK_STAT, ZERO, ZERO);
    triplet(PU_DIS, PU_EN, PU_STAT, ZERO, ZERO);
    check(pullup_on, ~32'h0F0000C0);
    mask_test();
    drive_test();
    freeze_test();
    periph_test();
    refuse_test();
    final_report();
  end
endmodule
`default_nettype wire
